/* File: shared/sarop_pkg.sv */
// Shared constants and types for the converter output port
package sarop_pkg;

   // Result width and frame length
   localparam int RES_W = 18;
   localparam logic [4:0] FRAME_BITS = 5'h12;
   localparam logic [4:0] LAST_BIT = 5'h11;
   localparam int CNT_W = 5;

   // Interface modes on the two mode pins
   localparam logic [1:0] MODE_SERIAL = 2'h3;

   // Bus bit positions of the dual-use serial pins
   localparam int BIT_SDO = 10;
   localparam int BIT_SCLK = 11;
   localparam int BIT_SYNC = 12;
   localparam int BIT_RDERR = 13;
   localparam int BIT_HIGH_LO = 14;
   localparam int BIT_HIGH_HI = 17;
   localparam int BIT_MSB = 17;

   // Internal serial clock: quarter period in system cycles, and phase codes
   localparam int INT_SCLK_HALF = 2;
   localparam logic [1:0] PH_DATA = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_FALL = 2'h3;

   // Result FIFO depth
   localparam int FIFO_DEPTH = 16;

   // Pins and straps seen from outside the clock domain
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic [1:0] mode;
      logic output_coding_select;
      logic clock_source_select;
      logic sync_polarity_select;
      logic clock_invert_select;
      logic read_timing_or_chain_input;
      logic sclk;
   } sarop_pins_t;

   // Conversion result handed over by the converter core
   typedef struct packed {
      logic valid;
      logic [RES_W-1:0] data;
   } sarop_result_t;

   // Serial read sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE = 2'b10
   } sarop_state_t;

endpackage

/* File: hw/sarop_fifo.sv */
// Result FIFO between the converter core and the output register
`timescale 1ns/10ps
`default_nettype none
module sarop_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // Handshakes on both sides; full and empty come from the count
   assign push = in_valid && (count_q != FULL);
   assign pop = out_ready && (count_q != '0);
   assign in_ready = (count_q != FULL);
   assign out_valid = (count_q != '0);
   assign out_data = mem[rd_q];

   // Storage and pointers
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else if (clock_enable) begin
         if (push) begin
            mem[wr_q] <= in_data;
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* File: hw/sarop_top.sv */
// Output port of the converter: busy, parallel bus and serial port
`timescale 1ns/10ps
`default_nettype none
module sarop_top #(
   parameter int RES_W = sarop_pkg::RES_W,
   parameter int FIFO_DEPTH = sarop_pkg::FIFO_DEPTH,
   parameter int INT_SCLK_HALF = sarop_pkg::INT_SCLK_HALF
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic conv_start,
   input wire sarop_pkg::sarop_result_t conv_result,
   output logic conv_ready,
   output logic busy,
   input wire sarop_pkg::sarop_pins_t pins,
   output logic [RES_W-1:0] bus_out,
   output logic [RES_W-1:0] bus_oe
);
   localparam int DIV_W = $clog2(INT_SCLK_HALF + 1);

   // Whole module state
   typedef struct packed {
      sarop_pkg::sarop_pins_t pin1;
      sarop_pkg::sarop_pins_t pin2;
      logic sclk_prev;
      sarop_pkg::sarop_state_t state;
      logic [RES_W-1:0] result;
      logic [RES_W-1:0] shift;
      logic [sarop_pkg::CNT_W-1:0] bitcnt;
      logic [DIV_W-1:0] div;
      logic [1:0] phase;
      logic sclk_int;
      logic have_data;
      logic busy;
      logic rderr;
      logic conv_ready;
      logic [RES_W-1:0] bus;
      logic [RES_W-1:0] oe;
   } sarop_regs_t;

   sarop_regs_t q;
   sarop_regs_t d;

   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [RES_W-1:0] fifo_out_data;
   logic fifo_pop;

   // Applies the selected output coding to a raw offset-binary result
   function automatic logic [RES_W-1:0] sarop_code(input logic [RES_W-1:0] raw,
                                                  input logic twos);
      logic [RES_W-1:0] r;
      r = raw;
      r[RES_W-1] = raw[RES_W-1] ^ twos;
      return r;
   endfunction

   // Results wait here until the output register is free
   sarop_fifo #(
      .WIDTH(RES_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .in_valid(conv_result.valid),
      .in_data(conv_result.data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_pop)
   );

   // Next-state logic
   always_comb begin
      logic enabled;
      logic serial;
      logic ext;
      logic upd_edge;
      logic div_wrap;
      logic int_start;
      logic reading;
      sarop_pkg::sarop_pins_t p;
      enabled = 1'b0;
      serial = 1'b0;
      ext = 1'b0;
      upd_edge = 1'b0;
      div_wrap = 1'b0;
      int_start = 1'b0;
      reading = 1'b0;
      p = q.pin2;
      d = q;
      fifo_pop = 1'b0;

      // Two-stage synchronisers for every pin
      d.pin1 = pins;
      d.pin2 = q.pin1;
      d.sclk_prev = p.sclk;
      d.rderr = 1'b0;
      d.conv_ready = fifo_in_ready;

      enabled = !p.cs_n && !p.rd_n;
      serial = (p.mode == sarop_pkg::MODE_SERIAL);
      ext = p.clock_source_select;

      // External clock edge that updates data; counted only while selected
      if (p.clock_invert_select) begin
         upd_edge = !p.sclk && q.sclk_prev && !p.cs_n;
      end else begin
         upd_edge = p.sclk && !q.sclk_prev && !p.cs_n;
      end

      // Busy rises on a conversion start unless a result is latched in the same cycle
      if (conv_start) begin
         d.busy = 1'b1;
      end

      reading = (q.state == sarop_pkg::ST_SHIFT);

      // A finished conversion during an unfinished external read loses the data
      if (serial && ext && reading && fifo_out_valid) begin
         d.rderr = 1'b1;
         // Hold off a new read until the host deselects
         d.state = sarop_pkg::ST_DONE;
         reading = 1'b0;
      end

      // Latch the next result when no read holds the register
      if (fifo_out_valid && !reading && !(enabled && q.state == sarop_pkg::ST_DONE)) begin
         fifo_pop = 1'b1;
         d.result = fifo_out_data;
         d.have_data = 1'b1;
         d.busy = 1'b0;
      end

      // Serial read sequencer
      unique case (q.state)
         sarop_pkg::ST_IDLE: begin
            d.sclk_int = 1'b0;
            d.div = '0;
            d.phase = sarop_pkg::PH_DATA;
            // Internal clock waits for end of conversion unless read-timing is high
            int_start = ext || p.read_timing_or_chain_input || !q.busy;
            if (serial && enabled && q.have_data && !fifo_pop && int_start) begin
               d.state = sarop_pkg::ST_SHIFT;
               d.shift = sarop_code(q.result, p.output_coding_select);
               d.bitcnt = '0;
               d.have_data = 1'b0;
            end
         end
         sarop_pkg::ST_SHIFT: begin
            if (!enabled || !serial) begin
               d.state = sarop_pkg::ST_IDLE;
            end else if (ext) begin
               // Shift on each update edge; chain input fills from below
               if (upd_edge) begin
                  d.shift = {q.shift[RES_W-2:0], p.read_timing_or_chain_input};
                  d.bitcnt = q.bitcnt + sarop_pkg::CNT_W'(1);
                  if (q.bitcnt == sarop_pkg::LAST_BIT) begin
                     d.state = sarop_pkg::ST_DONE;
                  end
               end
            end else begin
               // Internal clock: data moves mid-low so both edges see it stable
               div_wrap = (q.div == DIV_W'(INT_SCLK_HALF - 1));
               d.div = div_wrap ? '0 : q.div + DIV_W'(1);
               if (div_wrap) begin
                  d.phase = q.phase + 2'h1;
                  if (q.phase == sarop_pkg::PH_DATA) begin
                     d.sclk_int = 1'b1;
                  end
                  if (q.phase == sarop_pkg::PH_RISE + 2'h1) begin
                     d.sclk_int = 1'b0;
                  end
                  if (q.phase == sarop_pkg::PH_FALL) begin
                     d.bitcnt = q.bitcnt + sarop_pkg::CNT_W'(1);
                     d.shift = {q.shift[RES_W-2:0], 1'b0};
                     if (q.bitcnt == sarop_pkg::LAST_BIT) begin
                        d.state = sarop_pkg::ST_DONE;
                     end
                  end
               end
            end
         end
         sarop_pkg::ST_DONE: begin
            d.sclk_int = 1'b0;
            if (!enabled || !serial) begin
               d.state = sarop_pkg::ST_IDLE;
            end else if (ext && upd_edge) begin
               d.shift = {q.shift[RES_W-2:0], p.read_timing_or_chain_input};
            end
         end
         default: begin
            d.state = sarop_pkg::ST_IDLE;
         end
      endcase

      // Output pins: parallel word, or the serial port on bits ten to thirteen
      d.bus = sarop_code(d.result, p.output_coding_select);
      d.oe = '0;
      if (serial) begin
         d.bus[sarop_pkg::BIT_SDO] = d.shift[sarop_pkg::BIT_MSB];
         d.bus[sarop_pkg::BIT_SCLK] = d.sclk_int ^ p.clock_invert_select;
         d.bus[sarop_pkg::BIT_SYNC] = (d.state == sarop_pkg::ST_SHIFT) ^
                                      p.sync_polarity_select;
         d.bus[sarop_pkg::BIT_RDERR] = d.rderr && ext;
         if (enabled) begin
            d.oe[sarop_pkg::BIT_HIGH_HI:sarop_pkg::BIT_SDO] = '1;
            d.oe[sarop_pkg::BIT_SCLK] = !ext;
            d.oe[sarop_pkg::BIT_SYNC] = !ext;
         end
      end else if (enabled) begin
         d.oe = '1;
      end
      // Disabled bus stays released
   end

   // State register; reset aborts any read and clears busy
   always_ff @(posedge clock) begin
      if (reset) begin
         q <= '0;
         // Synchronisers start at the idle pin levels, so no false select
         q.pin1.cs_n <= 1'b1;
         q.pin1.rd_n <= 1'b1;
         q.pin2.cs_n <= 1'b1;
         q.pin2.rd_n <= 1'b1;
      end else if (clock_enable) begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops
   assign busy = q.busy;
   assign bus_out = q.bus;
   assign bus_oe = q.oe;
   assign conv_ready = q.conv_ready;
endmodule
`default_nettype wire

/* File: tb/sarop_top_monitor.sv */
// Checker on the converter output port
`timescale 1ns/10ps
`default_nettype none
module sarop_top_monitor #(
   parameter int RES_W = 18
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic conv_start,
   input wire sarop_pkg::sarop_result_t conv_result,
   input wire logic conv_ready,
   input wire logic busy,
   input wire sarop_pkg::sarop_pins_t pins,
   input wire logic [RES_W-1:0] bus_out,
   input wire logic [RES_W-1:0] bus_oe
);
   logic si, se, sel;
   // Serial with internal or external clock, and bus selected, from raw pins
   assign si = pins.mode == sarop_pkg::MODE_SERIAL && !pins.clock_source_select;
   assign se = pins.mode == sarop_pkg::MODE_SERIAL && pins.clock_source_select;
   assign sel = !pins.cs_n && !pins.rd_n;
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset || !clock_enable);
   a_busy_on_start:
   assert property (conv_start |=> busy) else $error("busy not raised");
   a_reset_idle:
   assert property ($fell(reset) |-> !busy && bus_oe == '0) else $error("not idle");
   a_oe_needs_sel:
   assert property (bus_oe[10] |-> $past(sel, 3)) else $error("bus driven unselected");
   a_par_full_bus:
   assert property (pins.mode != sarop_pkg::MODE_SERIAL && $past(sel, 3) && $past(sel, 4)
      |-> &bus_oe) else $error("parallel bus not driven");
   a_err_one_cycle:
   assert property (se && $rose(bus_out[13]) |=> !bus_out[13]) else $error("flag too long");
   a_ext_sclk_in:
   assert property (se && $past(se, 3) |-> !bus_oe[11]) else $error("clock pin driven");
   a_int_data_hold:
   assert property (si && $past(si, 3) && $past(bus_oe[11]) && bus_oe[11]
      && $changed(bus_out[11]) |-> $stable(bus_out[10])) else $error("data moved");
   a_sync_in_frame:
   assert property (si && $past(si, 3) && $past(bus_oe[11]) && bus_oe[11]
      && $changed(bus_out[11]) |-> bus_out[12] != pins.sync_polarity_select)
      else $error("sync inactive in frame");
endmodule
bind sarop_top sarop_top_monitor #(.RES_W(RES_W)) u_mon (.clock(clock), .reset(reset),
   .clock_enable(clock_enable), .conv_start(conv_start), .conv_result(conv_result),
   .conv_ready(conv_ready), .busy(busy), .pins(pins), .bus_out(bus_out), .bus_oe(bus_oe));
`default_nettype wire

/* File: tb/sarop_host_model.sv */
// Host model: select, read strobe, serial clock and capture
`timescale 1ns/10ps
`default_nettype none
module sarop_host_model (
   input wire logic clock,
   input wire logic [17:0] bus_out,
   input wire logic [17:0] bus_oe,
   output logic cs_n,
   output logic rd_n,
   output logic sclk
);
   logic sdo;
   // A released data pin reads unknown, so no capture matches by luck
   assign sdo = bus_oe[10] ? bus_out[10] : 1'bx;
   initial {cs_n, rd_n, sclk} = 3'h6;
   // Select and read strobe move together just after an edge
   task automatic select(input logic on);
      @(posedge clock);
      #1;
      cs_n = !on;
      rd_n = !on;
   endtask
   // External clock: n update edges, sampled before the first and after each
   task automatic read_ext(input logic inv, input int n, output logic [18:0] w);
      w = '0;
      sclk = inv;
      select(1'b1);
      #63;
      w[18] = sdo;
      for (int k = 17; k >= 18 - n; k--) begin
         #40 sclk = !inv;
         #40 sclk = inv;
         w[k] = sdo;
      end
   endtask
   // Internal clock: capture at each pulse of the port's clock, count pulses
   task automatic read_int(input logic inv, output logic [17:0] w, output int n);
      logic p;
      n = 0;
      w = '0;
      p = inv;
      select(1'b1);
      repeat (220) begin
         @(posedge clock);
         #1;
         if (bus_oe[11] && p == inv && bus_out[11] == !inv) begin
            if (n < 18) w[17 - n] = sdo;
            n++;
         end
         p = bus_oe[11] ? bus_out[11] : inv;
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/sar_adc_output_port_tb.sv */
// Bench for the converter output port
`timescale 1ns/10ps
`default_nettype none
module sar_adc_output_port_tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic clock_enable = 1'b1;
   logic conv_start = 1'b0;
   logic conv_ready, busy, cs_n, rd_n, host_sclk, seen;
   logic [17:0] bus_out, bus_oe;
   logic [18:0] w;
   logic [31:0] seed = 32'h1d;
   sarop_pkg::sarop_result_t conv_result = '0;
   sarop_pkg::sarop_pins_t cfg = '0;
   sarop_pkg::sarop_pins_t pins;
   logic [17:0] exp_q[$];
   int n_mismatch = 0;
   int num_checks = 0;
   int n;
   always #5 clock = !clock;
   // Pin levels; the clock pin carries whichever side enables it
   always_comb begin
      pins = cfg;
      pins.cs_n = cs_n;
      pins.rd_n = rd_n;
      pins.sclk = bus_oe[11] ? bus_out[11] : host_sclk;
   end
   sarop_top u_dut (.clock(clock), .reset(reset), .clock_enable(clock_enable),
      .conv_start(conv_start), .conv_result(conv_result), .conv_ready(conv_ready),
      .busy(busy), .pins(pins), .bus_out(bus_out), .bus_oe(bus_oe));
   sarop_host_model u_host (.clock(clock), .bus_out(bus_out), .bus_oe(bus_oe),
      .cs_n(cs_n), .rd_n(rd_n), .sclk(host_sclk));
   // Helpers: cycle wait, random words, expected coding, comparison, verdict
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [17:0] code(input logic [17:0] r);
      return {r[17] ^ cfg.output_coding_select, r[16:0]};
   endfunction
   task automatic chk(input string what, input logic [18:0] e, input logic [18:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One conversion of a random word; busy rises, then falls once latched
   task automatic convert();
      seed = xs(seed);
      conv_start = 1'b1;
      cyc(1);
      conv_start = 1'b0;
      chk("busy", 19'h1, {18'h0, busy});
      cyc(2);
      conv_result = {1'b1, seed[17:0]};
      cyc(1);
      conv_result.valid = 1'b0;
      exp_q.push_back(seed[17:0]);
      for (int t = 0; t < 20 && busy !== 1'b0; t++) cyc(1);
      chk("busy", 19'h0, {18'h0, busy});
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      #1;
      reset = 1'b0;
      cyc(2);
      chk("ready", 19'h1, {18'h0, conv_ready});
      for (int m = 0; m < 3; m++) begin
         cfg.mode = m[1:0];
         cfg.output_coding_select = m[0];
         convert();
         u_host.select(1'b1);
         cyc(4);
         chk("oe", 19'h3ffff, {1'b0, bus_oe});
         chk("word", {1'b0, code(exp_q.pop_front())}, {1'b0, bus_out});
         u_host.select(1'b0);
         cyc(4);
         chk("oe", 19'h0, {1'b0, bus_oe});
      end
      cfg.mode = sarop_pkg::MODE_SERIAL;
      cfg.read_timing_or_chain_input = 1'b1;
      for (int i = 0; i < 4; i++) begin
         cfg.sync_polarity_select = i[0];
         cfg.clock_invert_select = i[1];
         convert();
         u_host.read_int(i[1], w[17:0], n);
         chk("bits", 19'd18, n[18:0]);
         chk("serial", {1'b0, code(exp_q.pop_front())}, {1'b0, w[17:0]});
         u_host.select(1'b0);
         cyc(6);
      end
      cfg.clock_source_select = 1'b1;
      for (int i = 0; i < 3; i++) begin
         cfg.clock_invert_select = i[0];
         convert();
         cfg.read_timing_or_chain_input = seed[20];
         u_host.read_ext(i[0], 18, w);
         chk("serial", {code(exp_q.pop_front()), seed[20]}, w);
         u_host.select(1'b0);
         cyc(6);
      end
      // A read cut short by the next result: flag pulse, old word dropped
      convert();
      u_host.read_ext(1'b0, 5, w);
      cyc(1);
      seen = 1'b0;
      fork
         convert();
         repeat (30) begin
            cyc(1);
            seen = seen | bus_out[13];
         end
      join
      chk("flag", 19'h1, {18'h0, seen});
      void'(exp_q.pop_front());
      u_host.select(1'b0);
      cyc(6);
      cfg.read_timing_or_chain_input = seed[20];
      u_host.read_ext(1'b0, 18, w);
      chk("serial", {code(exp_q.pop_front()), seed[20]}, w);
      // Reset in mid-conversion
      conv_start = 1'b1;
      cyc(1);
      conv_start = 1'b0;
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      cyc(1);
      chk("busy", 19'h0, {18'h0, busy});
      end_of_test();
   end
   // Watchdog well beyond the expected run
   initial begin
      #300000;
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
